/* bedg_gating.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bedg_map.svh"
module bedg_gating
	import bedg_pkg::*;
#(
	parameter int TICKS_PER_SEC = `BEDG_TICKS_PER_SEC
)
(
	// System clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Link side, on the received clock
	input wire logic link_clk_in,
	input wire logic link_data_in,
	input wire logic ref_bit_in,
	input wire logic pattern_start_in,
	output logic trigger_out,
	// Input and trigger settings
	input wire logic polarity_a_in,
	input wire logic [15:0] delay_ps_in,
	input wire bedg_trig_t trigger_mode_in,
	input wire logic stretched_in,
	input wire logic [1:0] clock_band_code_in,
	// Pattern lock
	input wire logic pattern_lock_control_auto_in,
	input wire logic pattern_lock_control_once_in,
	input wire logic [3:0] sync_threshold_exp_in,
	input wire logic sync_found_in,
	// Gating settings
	input wire logic gate_on_in,
	input wire logic burst_on_in,
	input wire logic burst_gate_in,
	input wire bedg_gate_mode_t gate_mode_in,
	input wire bedg_manner_t gate_manner_in,
	input wire logic [23:0] gate_time_s_in,
	input wire logic [9:0] gate_errors_in,
	input wire logic [3:0] gate_bits_exp_in,
	// Measurement mode and error location
	input wire bedg_meas_t meas_mode_in,
	input wire logic prbs_selected_in,
	input wire logic [31:0] pattern_len_in,
	input wire logic [31:0] block_start_in,
	input wire logic [31:0] block_len_in,
	input wire logic [31:0] bit_addr_in,
	input wire logic error_position_capture_start_in,
	// Eye result
	input wire logic eye_valid_in,
	input wire logic [63:0] eye_height_in,
	// Status and results
	output logic errors_out,
	output logic [15:0] sample_delay_ps_out,
	output logic [1:0] clock_band_code_out,
	output logic resync_req_out,
	output logic sync_locked_out,
	output logic gate_active_out,
	output logic gate_done_out,
	output logic config_reject_out,
	output logic results_valid_out,
	output logic prev_valid_out,
	output logic [31:0] err_count_out,
	output logic [49:0] bit_count_out,
	output logic [31:0] prev_err_count_out,
	output logic [49:0] prev_bit_count_out,
	output logic error_position_capture_busy_out,
	output logic [63:0] eye_height_out
);

	// ==========================================
	// Parameter check
	if (TICKS_PER_SEC < 1 || TICKS_PER_SEC >= (1 << 27))
	begin : g_bad_ticks
		$error("TICKS_PER_SEC does not fit the 27-bit tick counter");
	end

	localparam logic [26:0] TICK_LAST = 27'(TICKS_PER_SEC - 1);
	localparam logic [4:0] STRETCH_CYC = 5'(`BEDG_STRETCH_CYC);

	// Ten to the given power, for bit periods and loss windows
	function automatic logic [49:0] pow10(input logic [3:0] e);
		logic [49:0] r;
		r = 50'd1;
		for (int i = 0; i < 15; i++)
		begin
			if (4'(i) < e)
				r = 50'(r * 50'd10);
		end
		return r;
	endfunction

	// ==========================================
	// Link domain reset: async assert, sync release
	logic [1:0] lrst_sync_reg;
	always_ff @(posedge link_clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
			lrst_sync_reg <= 2'h0;
		else
			lrst_sync_reg <= {lrst_sync_reg[0], 1'b1};
	end

	bedg_link_st_t l_reg, l_next;
	bedg_sys_st_t s_reg, s_next;

	// ==========================================
	// Link domain: compare, qualify, trigger
	logic [31:0] l_off;
	logic l_qual;
	logic l_err;
	always_comb
	begin
		l_next = l_reg;
		l_off = 32'h0;
		l_qual = 1'b0;
		// Word stays still in sys domain until ack returns
		l_next.req_s1 = s_reg.req_tgl;
		l_next.req_s2 = l_reg.req_s1;
		if (l_reg.req_s2 != l_reg.ack)
		begin
			l_next.cfg = s_reg.cfg;
			l_next.ack = l_reg.req_s2;
		end
		l_err = (link_data_in ^ l_reg.cfg.polarity_a) ^ ref_bit_in;
		l_next.pos = pattern_start_in ? 32'h0 : l_reg.pos + 32'h1;
		// Distance into the block, wrapping at pattern end
		if (l_reg.pos >= l_reg.cfg.start)
			l_off = l_reg.pos - l_reg.cfg.start;
		else
			l_off = l_reg.pos + l_reg.cfg.plen - l_reg.cfg.start;
		case (l_reg.cfg.meas)
			BEDG_MM_BIT: l_qual = (l_reg.pos == l_reg.cfg.addr);
			BEDG_MM_BLOCK: l_qual = (l_off < l_reg.cfg.blen);
			default: l_qual = 1'b1;
		endcase
		// One toggle per counted bit and per counted error
		if (l_qual)
		begin
			l_next.bit_tgl = ~l_reg.bit_tgl;
			if (l_err)
				l_next.err_tgl = ~l_reg.err_tgl;
		end
		l_next.div = l_reg.div + 3'h1;
		if (l_reg.cfg.trig == BEDG_TRIG_DIVIDED_CLOCK)
			l_next.trig = l_next.div[`BEDG_TRIG_DIV_BIT];
		else
			l_next.trig = pattern_start_in;
	end

	// Link domain registers
	always_ff @(posedge link_clk_in or negedge lrst_sync_reg[1])
	begin
		if (!lrst_sync_reg[1])
			l_reg <= '0;
		else
			l_reg <= l_next;
	end

	// ==========================================
	// System domain: lock, gating, outputs
	bedg_cfg_t want;
	logic ev_err, ev_bit, cnt_en, per_end, restart;
	logic [49:0] win;
	always_comb
	begin
		s_next = s_reg;
		restart = 1'b0;
		per_end = 1'b0;
		s_next.reject = 1'b0;
		// Synchronisers; only the last two stages feed edge logic
		s_next.ack_s1 = l_reg.ack;
		s_next.ack_s2 = s_reg.ack_s1;
		s_next.err_s = {s_reg.err_s[1:0], l_reg.err_tgl};
		s_next.bit_s = {s_reg.bit_s[1:0], l_reg.bit_tgl};
		s_next.burst_s = {s_reg.burst_s[0], burst_gate_in};
		ev_err = s_reg.err_s[2] ^ s_reg.err_s[1];
		ev_bit = s_reg.bit_s[2] ^ s_reg.bit_s[1];

		// Settings for the link; PRBS forces whole-pattern
		want.polarity_a = polarity_a_in;
		want.trig = trigger_mode_in;
		want.meas = (prbs_selected_in || meas_mode_in == BEDG_MM_BLOCK + 2'h1) ?
			BEDG_MM_WHOLE : meas_mode_in;
		want.plen = pattern_len_in;
		want.start = block_start_in;
		want.blen = block_len_in;
		want.addr = bit_addr_in;
		if (s_reg.req_tgl == s_reg.ack_s2 && want != s_reg.cfg)
		begin
			s_next.cfg = want;
			s_next.req_tgl = ~s_reg.req_tgl;
		end

		// Band and delay; no delay on the through path
		s_next.band = clock_band_code_in;
		s_next.delay = (clock_band_code_in == 2'h0) ? 16'h0000 : delay_ps_in;
		s_next.eye = eye_valid_in ? eye_height_in : `BEDG_NAN_DOUBLE;

		// Error pulse: one cycle or stretched
		if (ev_err)
			s_next.stretch = stretched_in ? STRETCH_CYC : 5'h1;
		else if (s_reg.stretch != 5'h0)
			s_next.stretch = s_reg.stretch - 5'h1;
		s_next.err_o = (s_next.stretch != 5'h0);

		// Loss threshold; out-of-range values are refused
		if (sync_threshold_exp_in != s_reg.thr)
		begin
			if (sync_threshold_exp_in >= `BEDG_THR_MIN && sync_threshold_exp_in <= `BEDG_THR_MAX)
				s_next.thr = sync_threshold_exp_in;
			else
				s_next.reject = 1'b1;
		end
		// Window of 10^(k+1) bits, lost at ten errors: ratio 1E-k
		win = pow10(s_reg.thr + 4'h1);
		case (s_reg.sst)
			BEDG_SY_SEARCH:
				if (sync_found_in)
				begin
					s_next.sst = BEDG_SY_LOCKED;
					s_next.loss_bits = 30'h0;
					s_next.loss_errs = 4'h0;
				end
			BEDG_SY_LOCKED:
			begin
				s_next.loss_bits = s_reg.loss_bits + 30'(ev_bit);
				s_next.loss_errs = s_reg.loss_errs + 4'(ev_err);
				if (s_next.loss_errs >= `BEDG_LOSS_ERRS)
					s_next.sst = pattern_lock_control_auto_in ? BEDG_SY_SEARCH : BEDG_SY_LOST;
				else if (50'(s_next.loss_bits) >= win)
				begin
					s_next.loss_bits = 30'h0;
					s_next.loss_errs = 4'h0;
				end
			end
			BEDG_SY_LOST:
				if (pattern_lock_control_auto_in)
					s_next.sst = BEDG_SY_SEARCH;
			default: s_next.sst = BEDG_SY_SEARCH;
		endcase
		if (pattern_lock_control_once_in)
			s_next.sst = BEDG_SY_SEARCH;

		// Gating settings; a change other than manner drops all past results
		s_next.manner = gate_manner_in;
		if (gate_mode_in != s_reg.mode)
		begin
			if (gate_mode_in == BEDG_GM_REPEAT + 2'h1)
				s_next.reject = 1'b1;
			else
			begin
				s_next.mode = gate_mode_in;
				restart = 1'b1;
			end
		end
		if (gate_time_s_in != s_reg.per_time)
		begin
			if (gate_time_s_in >= `BEDG_TIME_MIN_S && gate_time_s_in <= `BEDG_TIME_MAX_S)
			begin
				s_next.per_time = gate_time_s_in;
				restart = 1'b1;
			end
			else
				s_next.reject = 1'b1;
		end
		if (gate_errors_in != s_reg.per_errs)
		begin
			if (gate_errors_in == 10'd10 || gate_errors_in == 10'd100 || gate_errors_in == 10'd1000)
			begin
				s_next.per_errs = gate_errors_in;
				restart = 1'b1;
			end
			else
				s_next.reject = 1'b1;
		end
		if (gate_bits_exp_in != s_reg.per_exp)
		begin
			if (gate_bits_exp_in >= `BEDG_BITS_EXP_MIN && gate_bits_exp_in <= `BEDG_BITS_EXP_MAX)
			begin
				s_next.per_exp = gate_bits_exp_in;
				restart = 1'b1;
			end
			else
				s_next.reject = 1'b1;
		end

		// Accumulate while running, locked and inside a burst
		cnt_en = (s_reg.gst == BEDG_GS_RUN) && (s_reg.sst == BEDG_SY_LOCKED) &&
			(!burst_on_in || s_reg.burst_s[1]);
		if (cnt_en)
		begin
			s_next.err_cnt = s_reg.err_cnt + 32'(ev_err);
			s_next.bit_cnt = s_reg.bit_cnt + 50'(ev_bit);
		end
		// Elapsed time runs for the whole period
		if (s_reg.gst == BEDG_GS_RUN)
		begin
			if (s_reg.tick == TICK_LAST)
			begin
				s_next.tick = 27'h0;
				s_next.secs = s_reg.secs + 24'h1;
			end
			else
				s_next.tick = s_reg.tick + 27'h1;
		end
		case (s_reg.manner)
			BEDG_GB_ERRORS: per_end = (s_reg.err_cnt >= 32'(s_reg.per_errs));
			BEDG_GB_BITS: per_end = (s_reg.bit_cnt >= pow10(s_reg.per_exp));
			default: per_end = (s_reg.secs >= s_reg.per_time);
		endcase

		// Gating state machine
		case (s_reg.gst)
			BEDG_GS_IDLE:
				if (gate_on_in)
				begin
					s_next.gst = BEDG_GS_RUN;
					restart = 1'b1;
					s_next.valid = 1'b1;
				end
			BEDG_GS_RUN:
				if (!gate_on_in)
					s_next.gst = BEDG_GS_IDLE;
				else if (s_reg.mode != BEDG_GM_MANUAL && per_end)
				begin
					if (s_reg.mode == BEDG_GM_REPEAT)
					begin
						s_next.prev_err = s_reg.err_cnt;
						s_next.prev_bit = s_reg.bit_cnt;
						s_next.prev_valid = s_reg.valid;
						s_next.valid = 1'b1;
						restart = 1'b1;
					end
					else
						s_next.gst = BEDG_GS_DONE;
				end
			BEDG_GS_DONE:
				if (!gate_on_in)
					s_next.gst = BEDG_GS_IDLE;
			default: s_next.gst = BEDG_GS_IDLE;
		endcase
		// Setting change: past results invalid, present ones too unless running
		if (s_next.mode != s_reg.mode || s_next.per_time != s_reg.per_time ||
			s_next.per_errs != s_reg.per_errs || s_next.per_exp != s_reg.per_exp)
		begin
			s_next.valid = (s_next.gst == BEDG_GS_RUN);
			s_next.prev_valid = 1'b0;
		end
		if (restart)
		begin
			s_next.err_cnt = 32'h0;
			s_next.bit_cnt = 50'h0;
			s_next.tick = 27'h0;
			s_next.secs = 24'h0;
		end

		// Capture: busy until the next counted error
		if (s_reg.cap_busy && ev_err)
			s_next.cap_busy = 1'b0;
		if (error_position_capture_start_in)
		begin
			if (prbs_selected_in)
				s_next.reject = 1'b1;
			else
				s_next.cap_busy = 1'b1;
		end
	end

	// System domain registers with documented defaults
	always_ff @(posedge clk_in or negedge rst_n_in)
	begin
		if (!rst_n_in)
		begin
			s_reg <= '0;
			s_reg.thr <= `BEDG_THR_RST;
			s_reg.mode <= BEDG_GM_MANUAL;
			s_reg.manner <= BEDG_GB_TIME;
			s_reg.per_time <= `BEDG_TIME_RST_S;
			s_reg.per_errs <= `BEDG_ERR_RST;
			s_reg.per_exp <= `BEDG_BITS_EXP_RST;
			s_reg.delay <= `BEDG_DELAY_RST;
			s_reg.eye <= `BEDG_NAN_DOUBLE;
		end
		else
			s_reg <= s_next;
	end

	// ==========================================
	// Outputs, all from registers
	assign trigger_out = l_reg.trig;
	assign errors_out = s_reg.err_o;
	assign sample_delay_ps_out = s_reg.delay;
	assign clock_band_code_out = s_reg.band;
	assign resync_req_out = (s_reg.sst == BEDG_SY_SEARCH);
	assign sync_locked_out = (s_reg.sst == BEDG_SY_LOCKED);
	assign gate_active_out = (s_reg.gst == BEDG_GS_RUN);
	assign gate_done_out = (s_reg.gst == BEDG_GS_DONE);
	assign config_reject_out = s_reg.reject;
	assign results_valid_out = s_reg.valid;
	assign prev_valid_out = s_reg.prev_valid;
	assign err_count_out = s_reg.err_cnt;
	assign bit_count_out = s_reg.bit_cnt;
	assign prev_err_count_out = s_reg.prev_err;
	assign prev_bit_count_out = s_reg.prev_bit;
	assign error_position_capture_busy_out = s_reg.cap_busy;
	assign eye_height_out = s_reg.eye;

endmodule
`default_nettype wire

/* bedg_map.svh */
`ifndef BEDG_MAP_SVH
`define BEDG_MAP_SVH
// ==========================================
// Timing
`define BEDG_CLK_PERIOD_NS 10
`define BEDG_STRETCH_NS 200
`define BEDG_STRETCH_CYC ((`BEDG_STRETCH_NS + `BEDG_CLK_PERIOD_NS - 1) / `BEDG_CLK_PERIOD_NS)
`define BEDG_TICKS_PER_SEC 100000000
`define BEDG_TRIG_DIV_BIT 2
// ==========================================
// Gating period limits and reset values
`define BEDG_TIME_MIN_S 24'd1
`define BEDG_TIME_MAX_S 24'd8639999
`define BEDG_TIME_RST_S 24'd60
`define BEDG_ERR_RST 10'd100
`define BEDG_BITS_EXP_MIN 4'd7
`define BEDG_BITS_EXP_MAX 4'd15
`define BEDG_BITS_EXP_RST 4'd10
// ==========================================
// Sync loss threshold (decade exponent)
`define BEDG_THR_MIN 4'd1
`define BEDG_THR_MAX 4'd8
`define BEDG_THR_RST 4'd1
`define BEDG_LOSS_ERRS 4'd10
// ==========================================
// Misc reset values and codes
`define BEDG_DELAY_RST 16'h0000
`define BEDG_NAN_DOUBLE 64'h47d2_ced3_2a16_a1b1
`endif

/* bedg_pkg.sv */
`include "bedg_map.svh"
package bedg_pkg;
	typedef enum logic [1:0] {BEDG_GM_MANUAL = 2'h0, BEDG_GM_SINGLE = 2'h1,
		BEDG_GM_REPEAT = 2'h2} bedg_gate_mode_t;
	typedef enum logic [1:0] {BEDG_GB_TIME = 2'h0, BEDG_GB_ERRORS = 2'h1,
		BEDG_GB_BITS = 2'h2} bedg_manner_t;
	typedef enum logic [1:0] {BEDG_MM_WHOLE = 2'h0, BEDG_MM_BIT = 2'h1,
		BEDG_MM_BLOCK = 2'h2} bedg_meas_t;
	typedef enum logic {BEDG_TRIG_PATTERN = 1'h0, BEDG_TRIG_DIVIDED_CLOCK = 1'h1} bedg_trig_t;
	// Gray along search -> locked -> lost
	typedef enum logic [1:0] {BEDG_SY_SEARCH = 2'h0, BEDG_SY_LOCKED = 2'h1,
		BEDG_SY_LOST = 2'h3} bedg_sync_t;
	// Gray along idle -> run -> done
	typedef enum logic [1:0] {BEDG_GS_IDLE = 2'h0, BEDG_GS_RUN = 2'h1,
		BEDG_GS_DONE = 2'h3} bedg_gate_t;
	// Settings handed to the link domain
	typedef struct packed {
		logic polarity_a;
		bedg_trig_t trig;
		bedg_meas_t meas;
		logic [31:0] plen;
		logic [31:0] start;
		logic [31:0] blen;
		logic [31:0] addr;
	} bedg_cfg_t;
	typedef struct packed {
		bedg_cfg_t cfg;
		logic req_s1;
		logic req_s2;
		logic ack;
		logic [31:0] pos;
		logic err_tgl;
		logic bit_tgl;
		logic [2:0] div;
		logic trig;
	} bedg_link_st_t;
	typedef struct packed {
		bedg_cfg_t cfg;
		logic req_tgl;
		logic ack_s1;
		logic ack_s2;
		logic [2:0] err_s;
		logic [2:0] bit_s;
		logic [1:0] burst_s;
		bedg_sync_t sst;
		logic [3:0] thr;
		logic [29:0] loss_bits;
		logic [3:0] loss_errs;
		bedg_gate_t gst;
		bedg_gate_mode_t mode;
		bedg_manner_t manner;
		logic [23:0] per_time;
		logic [9:0] per_errs;
		logic [3:0] per_exp;
		logic [26:0] tick;
		logic [23:0] secs;
		logic [31:0] err_cnt;
		logic [49:0] bit_cnt;
		logic [31:0] prev_err;
		logic [49:0] prev_bit;
		logic valid;
		logic prev_valid;
		logic reject;
		logic [4:0] stretch;
		logic err_o;
		logic cap_busy;
		logic [1:0] band;
		logic [15:0] delay;
		logic [63:0] eye;
	} bedg_sys_st_t;
endpackage

/* bedg_gating_props.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bedg_map.svh"
// ==========================================
// Port checker for the gating block
module bedg_gating_props
	import bedg_pkg::*;
#(
	parameter int TICKS_PER_SEC = 100
)
(
	// Clock and reset
	input wire logic clk_in,
	input wire logic rst_n_in,
	// Watched settings
	input wire logic [15:0] delay_ps_in,
	input wire logic [1:0] clock_band_code_in,
	input wire logic stretched_in,
	input wire logic pattern_lock_control_once_in,
	input wire logic sync_found_in,
	input wire logic gate_on_in,
	input wire bedg_gate_mode_t gate_mode_in,
	input wire logic [9:0] gate_errors_in,
	input wire logic prbs_selected_in,
	input wire logic error_position_capture_start_in,
	input wire logic eye_valid_in,
	input wire logic [63:0] eye_height_in,
	// Watched results
	input wire logic errors_out,
	input wire logic [15:0] sample_delay_ps_out,
	input wire logic resync_req_out,
	input wire logic sync_locked_out,
	input wire logic gate_active_out,
	input wire logic gate_done_out,
	input wire logic config_reject_out,
	input wire logic results_valid_out,
	input wire logic error_position_capture_busy_out,
	input wire logic [63:0] eye_height_out
);
	default clocking cb @(posedge clk_in);
	endclocking
	default disable iff (!rst_n_in);
	// Run length of the error pulse; six bits cover a stretched pulse
	logic [5:0] hi_cnt_reg;
	always_ff @(posedge clk_in or negedge rst_n_in)
		if (!rst_n_in)
			hi_cnt_reg <= 6'h00;
		else
			hi_cnt_reg <= errors_out ? hi_cnt_reg + 6'h01 : 6'h00;
	a_delay_follow: assert property ($past(rst_n_in) |-> sample_delay_ps_out ==
		(($past(clock_band_code_in) == 2'h0) ? 16'h0000 : $past(delay_ps_in)))
		else $error("sample delay does not follow setting");
	a_pulse_width: assert property ($fell(errors_out) |->
		(stretched_in ? hi_cnt_reg >= 6'd20 : hi_cnt_reg == 6'd1))
		else $error("error pulse has wrong width");
	a_reject_bad: assert property ((gate_mode_in == 2'h3 ||
		!(gate_errors_in inside {10'd10, 10'd100, 10'd1000})) |=> config_reject_out)
		else $error("bad gating setting not refused");
	a_lock_found: assert property (resync_req_out && sync_found_in &&
		!pattern_lock_control_once_in |=> sync_locked_out && !resync_req_out)
		else $error("lock not taken when found");
	a_once_search: assert property (pattern_lock_control_once_in |=> resync_req_out)
		else $error("one-shot resync not started");
	a_gate_start: assert property (gate_on_in && !gate_active_out && !gate_done_out
		|=> gate_active_out && results_valid_out)
		else $error("gating did not start");
	a_gate_stop: assert property (gate_active_out && !gate_on_in |=> !gate_active_out)
		else $error("gating did not stop");
	a_cap_refuse: assert property (error_position_capture_start_in && prbs_selected_in &&
		!error_position_capture_busy_out |=> !error_position_capture_busy_out)
		else $error("capture started on pure sequence");
	a_cap_start: assert property (error_position_capture_start_in && !prbs_selected_in
		|=> error_position_capture_busy_out)
		else $error("capture busy not raised");
	a_eye_code: assert property ($past(rst_n_in) |-> eye_height_out ==
		($past(eye_valid_in) ? $past(eye_height_in) : `BEDG_NAN_DOUBLE))
		else $error("eye height code wrong");
endmodule
`default_nettype wire

/* bedg_tx_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ==========================================
// Transmitter under test: 256-bit repeating stream
module bedg_tx_model
(
	// Link clock
	input wire logic link_clk_in,
	// Serial stream
	output logic data_out,
	output logic ref_out,
	output logic start_out
);
	logic [7:0] pos_reg = 8'h00;
	logic [3:0] gap_reg = 4'h0;
	int pend = 0;
	// Queue n single-bit errors
	task automatic inject(input int n);
		pend += n;
	endtask
	initial
	begin
		data_out = 1'b0;
		ref_out = 1'b0;
		start_out = 1'b0;
	end
	// Launch on falling edge; errors twelve bits apart so no window sees ten
	always @(negedge link_clk_in)
	begin
		pos_reg <= pos_reg + 8'h01;
		ref_out <= ^(pos_reg & 8'hb4);
		start_out <= (pos_reg == 8'h00);
		data_out <= ^(pos_reg & 8'hb4) ^ (pend > 0 && gap_reg == 4'h0);
		gap_reg <= (gap_reg == 4'hb) ? 4'h0 : gap_reg + 4'h1;
		if (pend > 0 && gap_reg == 4'h0)
			pend--;
	end
endmodule
`default_nettype wire

/* bedg_gating_bench.sv */
`timescale 1ns/1ps
`default_nettype none
`include "bedg_map.svh"
// ==========================================
// Bench for the gating block
module bedg_gating_bench
	import bedg_pkg::*;
	;
	localparam int TPS = 20;
	logic clk_in, rst_n_in, link_clk_in, link_data_in, ref_bit_in, pattern_start_in;
	logic polarity_a_in, stretched_in, pattern_lock_control_auto_in, sync_found_in;
	logic pattern_lock_control_once_in, gate_on_in, burst_on_in, burst_gate_in;
	logic prbs_selected_in, error_position_capture_start_in, eye_valid_in;
	logic [1:0] clock_band_code_in, clock_band_code_out;
	logic [3:0] sync_threshold_exp_in, gate_bits_exp_in;
	logic [9:0] gate_errors_in;
	logic [15:0] delay_ps_in, sample_delay_ps_out;
	logic [23:0] gate_time_s_in;
	logic [31:0] pattern_len_in, block_start_in, block_len_in, bit_addr_in;
	logic [63:0] eye_height_in, eye_height_out;
	bedg_trig_t trigger_mode_in;
	bedg_gate_mode_t gate_mode_in;
	bedg_manner_t gate_manner_in;
	bedg_meas_t meas_mode_in;
	logic trigger_out, errors_out, resync_req_out, sync_locked_out, gate_active_out;
	logic gate_done_out, config_reject_out, results_valid_out, prev_valid_out;
	logic error_position_capture_busy_out;
	logic [31:0] err_count_out, prev_err_count_out;
	logic [49:0] bit_count_out, prev_bit_count_out;
	int err_total = 0;
	int n_tests = 0;
	int cyc = 0;
	int exp_q[$];
	bedg_gating #(.TICKS_PER_SEC(TPS)) uut (.clk_in, .rst_n_in, .link_clk_in, .link_data_in,
		.ref_bit_in, .pattern_start_in, .trigger_out, .polarity_a_in, .delay_ps_in,
		.trigger_mode_in, .stretched_in, .clock_band_code_in, .pattern_lock_control_auto_in,
		.pattern_lock_control_once_in, .sync_threshold_exp_in, .sync_found_in, .gate_on_in,
		.burst_on_in, .burst_gate_in, .gate_mode_in, .gate_manner_in, .gate_time_s_in,
		.gate_errors_in, .gate_bits_exp_in, .meas_mode_in, .prbs_selected_in, .pattern_len_in,
		.block_start_in, .block_len_in, .bit_addr_in, .error_position_capture_start_in,
		.eye_valid_in, .eye_height_in, .errors_out, .sample_delay_ps_out, .clock_band_code_out,
		.resync_req_out, .sync_locked_out, .gate_active_out, .gate_done_out, .config_reject_out,
		.results_valid_out, .prev_valid_out, .err_count_out, .bit_count_out, .prev_err_count_out,
		.prev_bit_count_out, .error_position_capture_busy_out, .eye_height_out);
	bedg_tx_model tx (.link_clk_in, .data_out(link_data_in), .ref_out(ref_bit_in),
		.start_out(pattern_start_in));
	// ==========================================
	// Clocks, timeout, helpers
	initial
	begin
		clk_in = 1'b0;
		forever #5 clk_in = ~clk_in;
	end
	initial
	begin
		link_clk_in = 1'b0;
		#3.3;
		forever #62.5 link_clk_in = ~link_clk_in;
	end
	// Hang guard, well above the expected run
	always @(posedge clk_in)
	begin
		cyc++;
		if (cyc == 60000)
		begin
			err_total++;
			tally_and_finish();
		end
	end
	task automatic tally_and_finish();
		if (err_total == 0 && n_tests > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask
	task automatic chk(input string nm, input logic [63:0] e, input logic [63:0] g);
		n_tests++;
		if (g !== e)
		begin
			err_total++;
			$display("mismatch %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic tick(input int n);
		repeat (n)
			@(negedge clk_in);
	endtask
	// Ask for n errors; a nonzero w notes the expected pulse width
	task automatic hit(input int n, input int w);
		if (w > 0)
			repeat (n)
				exp_q.push_back(w);
		tx.inject(n);
		tick(n * 150 + 60);
	endtask
	// Pulse watcher: each finished pulse, while notes are queued, against the oldest
	initial
	begin : pw
		int w;
		w = 0;
		forever
		begin
			@(negedge clk_in);
			if (errors_out === 1'b1)
				w++;
			else if (w > 0)
			begin
				if (exp_q.size() > 0)
					chk("err_pulse", exp_q.pop_front(), w);
				w = 0;
			end
		end
	end
	// ==========================================
	// Main sequence
	initial
	begin
		int i, n;
		logic [15:0] d;
		logic [63:0] e;
		rst_n_in = 1'b0;
		polarity_a_in = 1'b0;
		delay_ps_in = 16'h0000;
		trigger_mode_in = BEDG_TRIG_PATTERN;
		stretched_in = 1'b0;
		clock_band_code_in = 2'h1;
		pattern_lock_control_auto_in = 1'b1;
		pattern_lock_control_once_in = 1'b0;
		sync_threshold_exp_in = 4'h1;
		sync_found_in = 1'b1;
		gate_on_in = 1'b0;
		burst_on_in = 1'b0;
		burst_gate_in = 1'b0;
		gate_mode_in = BEDG_GM_MANUAL;
		gate_manner_in = BEDG_GB_TIME;
		gate_time_s_in = 24'd60;
		gate_errors_in = 10'd100;
		gate_bits_exp_in = 4'd10;
		meas_mode_in = BEDG_MM_WHOLE;
		prbs_selected_in = 1'b0;
		pattern_len_in = 32'h0000_0100;
		block_start_in = 32'h0000_0000;
		block_len_in = 32'h0000_0100;
		error_position_capture_start_in = 1'b0;
		eye_valid_in = 1'b0;
		eye_height_in = 64'h0;
		void'($urandom(32'h187c98a4));
		bit_addr_in = $urandom;
		// Reset is asynchronous in both domains, so two cycles suffice
		tick(2);
		rst_n_in = 1'b1;
		chk("resync", 1'b1, resync_req_out);
		chk("active", 1'b0, gate_active_out);
		chk("delay", 16'h0, sample_delay_ps_out);
		chk("eye", `BEDG_NAN_DOUBLE, eye_height_out);
		tick(40);
		chk("locked", 1'b1, sync_locked_out);
		for (i = 0; i < 4; i++)
		begin
			d = $urandom;
			delay_ps_in = d;
			clock_band_code_in = i[1:0];
			tick(2);
			chk("delay", (i == 0) ? 16'h0 : d, sample_delay_ps_out);
			chk("band", i, clock_band_code_out);
		end
		e = {$urandom, $urandom};
		eye_height_in = e;
		eye_valid_in = 1'b1;
		tick(2);
		chk("eye", e, eye_height_out);
		eye_valid_in = 1'b0;
		// Each bad value in turn, then all good again
		for (i = 0; i < 6; i++)
		begin
			gate_mode_in = (i == 0) ? bedg_gate_mode_t'(2'h3) : BEDG_GM_MANUAL;
			gate_errors_in = (i == 1) ? 10'd7 : 10'd100;
			gate_time_s_in = (i == 2) ? 24'd0 : 24'd60;
			gate_bits_exp_in = (i == 3) ? 4'd6 : 4'd10;
			sync_threshold_exp_in = (i == 4) ? 4'd9 : 4'd1;
			tick(2);
			chk("reject", i < 5, config_reject_out);
		end
		gate_on_in = 1'b1;
		tick(2);
		chk("valid", 1'b1, results_valid_out);
		n = 1 + $urandom % 4;
		hit(n, 1);
		burst_on_in = 1'b1;
		hit(2, 0);
		burst_gate_in = 1'b1;
		hit(1, 1);
		burst_on_in = 1'b0;
		stretched_in = 1'b1;
		hit(2, 200 / 10);
		stretched_in = 1'b0;
		prbs_selected_in = 1'b1;
		error_position_capture_start_in = 1'b1;
		tick(1);
		chk("cap_rej", 1'b1, config_reject_out);
		prbs_selected_in = 1'b0;
		tick(1);
		error_position_capture_start_in = 1'b0;
		chk("busy", 1'b1, error_position_capture_busy_out);
		hit(1, 1);
		chk("busy", 1'b0, error_position_capture_busy_out);
		gate_on_in = 1'b0;
		tick(2);
		chk("errs", n + 4, err_count_out);
		gate_mode_in = BEDG_GM_SINGLE;
		gate_manner_in = BEDG_GB_ERRORS;
		gate_errors_in = 10'd10;
		tick(2);
		gate_on_in = 1'b1;
		hit(10, 1);
		chk("done", 1'b1, gate_done_out);
		chk("errs", 10, err_count_out);
		gate_mode_in = BEDG_GM_REPEAT;
		tick(2);
		chk("valid", 1'b0, results_valid_out);
		gate_on_in = 1'b0;
		gate_manner_in = BEDG_GB_TIME;
		gate_time_s_in = 24'd1;
		gate_mode_in = BEDG_GM_SINGLE;
		tick(2);
		gate_on_in = 1'b1;
		tick(1);
		n = 0;
		while (gate_active_out === 1'b1 && n < 200)
		begin
			n++;
			tick(1);
		end
		chk("period", 1'b1, n >= TPS && n <= TPS + 2);
		gate_on_in = 1'b0;
		gate_mode_in = BEDG_GM_REPEAT;
		tick(2);
		gate_on_in = 1'b1;
		tick(2 * TPS + 5);
		chk("prev_valid", 1'b1, prev_valid_out);
		chk("active", 1'b1, gate_active_out);
		chk("prev_errs", 0, prev_err_count_out);
		gate_on_in = 1'b0;
		pattern_lock_control_auto_in = 1'b0;
		polarity_a_in = 1'b1;
		tick(600);
		chk("locked", 1'b0, sync_locked_out);
		chk("resync", 1'b0, resync_req_out);
		polarity_a_in = 1'b0;
		tick(100);
		pattern_lock_control_once_in = 1'b1;
		tick(1);
		pattern_lock_control_once_in = 1'b0;
		tick(1);
		chk("locked", 1'b1, sync_locked_out);
		pattern_lock_control_auto_in = 1'b1;
		trigger_mode_in = BEDG_TRIG_DIVIDED_CLOCK;
		tick(200);
		@(posedge trigger_out);
		n = 0;
		@(negedge link_clk_in);
		while (trigger_out === 1'b1)
		begin
			n++;
			@(negedge link_clk_in);
		end
		chk("trig_half", 4, n);
		tally_and_finish();
	end
endmodule
bind bedg_gating bedg_gating_props #(.TICKS_PER_SEC(TICKS_PER_SEC)) props_i (.clk_in,
	.rst_n_in, .delay_ps_in, .clock_band_code_in, .stretched_in, .pattern_lock_control_once_in,
	.sync_found_in, .gate_on_in, .gate_mode_in, .gate_errors_in, .prbs_selected_in,
	.error_position_capture_start_in, .eye_valid_in, .eye_height_in, .errors_out,
	.sample_delay_ps_out, .resync_req_out, .sync_locked_out, .gate_active_out, .gate_done_out,
	.config_reject_out, .results_valid_out, .error_position_capture_busy_out, .eye_height_out);
`default_nettype wire
